// *** rtl/pfd_pkg.sv ***
// pfd_pkg: register map, field layouts and encodings of the fault
// handling and output extension block.
// assumes a 32-bit register bus with one aligned word per register.
package pfd_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] FLT0_OFF = 8'h0c;
	localparam logic [7:0] FLT1_OFF = 8'h10;
	localparam logic [7:0] WEX_OFF = 8'h14;
	localparam logic [7:0] DRV_OFF = 8'h18;
	localparam logic [7:0] STATUS_OFF = 8'h1c;
	// four capture words, one per compare/capture channel
	localparam logic [7:0] CAPW_OFF = 8'h20;

	// ------------------------------------------------------------
	// reset values, writable bits, status layout
	// ------------------------------------------------------------
	localparam logic [31:0] FLT_RST = 32'h0000_0000;
	localparam logic [31:0] WEX_RST = 32'h0000_0000;
	localparam logic [31:0] DRV_RST = 32'h0000_0000;
	localparam logic [31:0] FLT_WMASK = 32'h0fff_fffb;
	localparam logic [31:0] WEX_WMASK = 32'hffff_0f03;
	localparam logic [31:0] DRV_WMASK = 32'hffff_ffff;
	localparam int NRF_BIT = 4;
	localparam int ALT_BIT = 8;
	// blanking prescaler multiplies the count by 64, a shift by 6
	localparam int PRESC_SHIFT = 6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// field encodings
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		CAP_OFF, CAP_PLAIN, CAP_LOWER, CAP_HIGHER,
		CAP_LOCLOW, CAP_LOCHIGH, CAP_EXTREM, CAP_MARK
	} pfd_plain_fault_capture_t;
	typedef enum logic [1:0] {HALT_OFF, HALT_HW, HALT_SW, HALT_NR} pfd_halt_t;
	typedef enum logic [1:0] {BLK_START, BLK_RISE, BLK_FALL, BLK_BOTH} pfd_blank_t;
	typedef enum logic [1:0] {FS_OFF, FS_EVT, FS_INV, FS_ALT} pfd_src_t;

	typedef struct packed {
		logic [3:0] rsv_hi;
		logic [3:0] recov_fault_filter;
		logic [7:0] blank_duration;
		logic blank_prescale_sel;
		pfd_plain_fault_capture_t plain_fault_capture;
		logic [1:0] fault_capture_channel;
		pfd_halt_t halt;
		logic restart;
		pfd_blank_t blank;
		logic fault_qualify_en;
		logic keep;
		logic rsv_lo;
		pfd_src_t fault_source_sel;
	} pfd_fctrl_t;

	typedef struct packed {
		logic [7:0] deadtime_high_cycles;
		logic [7:0] deadtime_low_cycles;
		logic [3:0] rsv_hi;
		logic [3:0] deadtime_gen_enable;
		logic [5:0] rsv_lo;
		logic [1:0] output_routing_sel;
	} pfd_wex_t;

	typedef struct packed {
		logic [3:0] nonrecov_filter_1;
		logic [3:0] nonrecov_filter_0;
		logic [7:0] output_invert;
		logic [7:0] nonrecov_override_level;
		logic [7:0] nonrecov_override_en;
	} pfd_drv_t;

	// byte-lane merge of a bus write into a register
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be, input logic [31:0] m);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b+:8] = (old[8*b+:8] & ~m[8*b+:8]) | (nw[8*b+:8] & m[8*b+:8]);
			end
		end
		return r;
	endfunction

endpackage

// *** rtl/pfd_filt.sv ***
// pfd_filt: digital filter for one fault event level.
// assumes the input is already synchronised to aclk.
`timescale 1ns/1ps
`default_nettype none
module pfd_filt (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// level and filter length
	input wire logic raw,
	input wire logic [3:0] len,
	// filtered level
	output logic filt
);
	logic filt_q;
	logic [3:0] run_q;

	// a change is accepted only after len consecutive differing samples
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			filt_q <= 1'b0;
			run_q <= 4'h0;
		end else if (raw == filt_q) begin
			run_q <= 4'h0;
		end else if ({1'b0, run_q} + 5'h01 >= {1'b0, len}) begin
			filt_q <= raw;
			run_q <= 4'h0;
		end else begin
			run_q <= run_q + 4'h1;
		end
	end

	assign filt = filt_q;

	filt_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		raw != filt_q && len > 4'h1 && run_q == 4'h0 |=> filt_q == $past(filt_q))
		else $error("filter accepted a change too early");

endmodule
`default_nettype wire

// *** rtl/pfd_fault_ctrl.sv ***
// pfd_fault_ctrl: recoverable fault handling, capture on fault, dead
// time, output routing and non-recoverable override of a control timer.
// assumes counter core inputs on aclk and event inputs asynchronous.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module pfd_fault_ctrl #(
	parameter int CNT_W = 24,
	parameter int RAMP_W = 2
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write channels
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read channels
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// event inputs, asynchronous
	input wire logic [1:0] match_capture_event_in,
	input wire logic timer_event_in_0,
	input wire logic timer_event_in_1,
	// counter core
	input wire logic [CNT_W-1:0] counter_value,
	input wire logic [RAMP_W-1:0] ramp_index,
	input wire logic period_start,
	input wire logic cycle_end,
	input wire logic [3:0] compare_output_state,
	// fault actions
	output logic [1:0] fault_state,
	output logic [1:0] fault_halt_hw,
	output logic [1:0] fault_halt_sw,
	output logic [1:0] fault_restart,
	output logic [1:0] fault_event_flag,
	output logic nonrecov_fault,
	// waveform pins
	output logic [7:0] wo_out,
	output logic [7:0] wo_oe
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	pfd_pkg::pfd_fctrl_t fc_q [2];
	pfd_pkg::pfd_wex_t wex_q;
	pfd_pkg::pfd_drv_t drv_q;
	logic [CNT_W-1:0] cc_q [4];
	logic [3:0] sync1_q, sync2_q, evt_f;
	logic [3:0] flen [4];
	logic cap_we [2];
	logic [CNT_W-1:0] cap_val [2];
	logic [1:0] fst, nr_req;
	logic nrf_q;
	logic [7:0] mtx, wv, wo_q, oe_q;

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	logic awready_q, wready_q, aw_have_q, w_have_q, bvalid_q;
	logic arready_q, rvalid_q, wr_go, wr_hit, rd_hit;
	logic [1:0] bresp_q, rresp_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q, rd_val;
	logic [3:0] wstrb_q;

	assign wr_go = aw_have_q && w_have_q && !bvalid_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= pfd_pkg::RESP_OKAY;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (awvalid && awready_q) begin
				awready_q <= 1'b0;
				aw_have_q <= 1'b1;
				awaddr_q <= awaddr;
			end
			if (wvalid && wready_q) begin
				wready_q <= 1'b0;
				w_have_q <= 1'b1;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? pfd_pkg::RESP_OKAY : pfd_pkg::RESP_SLVERR;
			end
			if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	always_comb begin
		case (awaddr_q)
			pfd_pkg::FLT0_OFF, pfd_pkg::FLT1_OFF, pfd_pkg::WEX_OFF,
			pfd_pkg::DRV_OFF, pfd_pkg::STATUS_OFF: wr_hit = 1'b1;
			default: wr_hit = awaddr_q[7:4] == pfd_pkg::CAPW_OFF[7:4] && awaddr_q[1:0] == 2'h0;
		endcase
	end

	always_comb begin
		rd_hit = 1'b1;
		rd_val = 32'h0000_0000;
		case (araddr)
			pfd_pkg::FLT0_OFF: rd_val = fc_q[0];
			pfd_pkg::FLT1_OFF: rd_val = fc_q[1];
			pfd_pkg::WEX_OFF: rd_val = wex_q;
			pfd_pkg::DRV_OFF: rd_val = drv_q;
			pfd_pkg::STATUS_OFF: begin
				rd_val[1:0] = fst;
				rd_val[pfd_pkg::NRF_BIT] = nrf_q;
				rd_val[pfd_pkg::ALT_BIT+:2] = {g_rf[1].alt_q, g_rf[0].alt_q};
			end
			default: begin
				rd_hit = araddr[7:4] == pfd_pkg::CAPW_OFF[7:4] && araddr[1:0] == 2'h0;
				if (rd_hit) begin
					rd_val = 32'(cc_q[araddr[3:2]]);
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= pfd_pkg::RESP_OKAY;
		end else if (arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_val;
			rresp_q <= rd_hit ? pfd_pkg::RESP_OKAY : pfd_pkg::RESP_SLVERR;
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fc_q[0] <= pfd_pkg::FLT_RST;
			fc_q[1] <= pfd_pkg::FLT_RST;
			wex_q <= pfd_pkg::WEX_RST;
			drv_q <= pfd_pkg::DRV_RST;
		end else if (wr_go) begin
			case (awaddr_q)
				pfd_pkg::FLT0_OFF: fc_q[0] <= pfd_pkg::wmerge(fc_q[0], wdata_q, wstrb_q,
					pfd_pkg::FLT_WMASK);
				pfd_pkg::FLT1_OFF: fc_q[1] <= pfd_pkg::wmerge(fc_q[1], wdata_q, wstrb_q,
					pfd_pkg::FLT_WMASK);
				pfd_pkg::WEX_OFF: wex_q <= pfd_pkg::wmerge(wex_q, wdata_q, wstrb_q,
					pfd_pkg::WEX_WMASK);
				pfd_pkg::DRV_OFF: drv_q <= pfd_pkg::wmerge(drv_q, wdata_q, wstrb_q,
					pfd_pkg::DRV_WMASK);
				default: ;
			endcase
		end
	end

	// capture words: a capture beats a bus write in the same cycle, fault 0 beats fault 1
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int c = 0; c < 4; c++) begin
				cc_q[c] <= '0;
			end
		end else begin
			if (wr_go && wr_hit && awaddr_q[7:4] == pfd_pkg::CAPW_OFF[7:4]) begin
				cc_q[awaddr_q[3:2]] <= CNT_W'(pfd_pkg::wmerge(32'(cc_q[awaddr_q[3:2]]),
					wdata_q, wstrb_q, 32'hffff_ffff));
			end
			for (int n = 1; n >= 0; n--) begin
				if (cap_we[n]) begin
					cc_q[fc_q[n].fault_capture_channel] <= cap_val[n];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// event input synchronisers and filters
	// ------------------------------------------------------------
	// fault sources must arrive as asynchronous levels, hence two flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
		end else begin
			sync1_q <= {timer_event_in_1, timer_event_in_0, match_capture_event_in};
			sync2_q <= sync1_q;
		end
	end

	assign flen[0] = fc_q[0].recov_fault_filter;
	assign flen[1] = fc_q[1].recov_fault_filter;
	assign flen[2] = drv_q.nonrecov_filter_0;
	assign flen[3] = drv_q.nonrecov_filter_1;

	for (genvar i = 0; i < 4; i++) begin : g_flt
		pfd_filt u_filt (
			.aclk(aclk),
			.aresetn(aresetn),
			.raw(sync2_q[i]),
			.len(flen[i]),
			.filt(evt_f[i])
		);
	end

	// ------------------------------------------------------------
	// recoverable faults
	// ------------------------------------------------------------
	for (genvar n = 0; n < 2; n++) begin : g_rf
		pfd_pkg::pfd_fctrl_t fc;
		logic src_lvl, blk_go, valid, rise, up, we, flag, cmp;
		logic cmp_prev_q, vprev_q, fstate_q, fstate_d, alt_q, trend_q;
		logic restart_q, flag_q, hw_q, sw_q;
		logic [13:0] blk_cnt_q, blk_load;
		logic [CNT_W-1:0] last, val;

		assign fc = fc_q[n];
		assign cmp = compare_output_state[n];
		assign last = cc_q[fc.fault_capture_channel];
		assign blk_load = fc.blank_prescale_sel ? {fc.blank_duration, 6'h00} :
			{6'h00, fc.blank_duration};

		always_comb begin
			case (fc.fault_source_sel)
				pfd_pkg::FS_EVT: src_lvl = evt_f[n];
				pfd_pkg::FS_INV: src_lvl = !evt_f[n];
				pfd_pkg::FS_ALT: src_lvl = alt_q;
				default: src_lvl = 1'b0;
			endcase
			case (fc.blank)
				pfd_pkg::BLK_START: blk_go = period_start;
				pfd_pkg::BLK_RISE: blk_go = cmp && !cmp_prev_q;
				pfd_pkg::BLK_FALL: blk_go = !cmp && cmp_prev_q;
				default: blk_go = cmp != cmp_prev_q;
			endcase
		end

		// a zero count means no blanking window
		assign valid = src_lvl && blk_cnt_q == 14'h0000
			&& !(fc.fault_qualify_en && !cmp);
		assign rise = valid && !vprev_q;
		assign up = counter_value > last;

		always_comb begin
			fstate_d = fstate_q;
			if (valid) begin
				fstate_d = 1'b1;
			end else if (!fc.keep || cycle_end) begin
				fstate_d = 1'b0;
			end
		end

		always_comb begin
			we = 1'b0;
			flag = 1'b0;
			val = counter_value;
			case (fc.plain_fault_capture)
				pfd_pkg::CAP_PLAIN: begin
					we = rise;
					flag = rise;
				end
				pfd_pkg::CAP_LOWER: begin
					we = rise && counter_value < last;
					flag = we;
				end
				pfd_pkg::CAP_HIGHER: begin
					we = rise && up;
					flag = we;
				end
				pfd_pkg::CAP_LOCLOW: begin
					we = rise;
					flag = rise && up && !trend_q;
				end
				pfd_pkg::CAP_LOCHIGH: begin
					we = rise;
					flag = rise && !up && trend_q;
				end
				pfd_pkg::CAP_EXTREM: begin
					we = rise;
					flag = rise && up != trend_q;
				end
				pfd_pkg::CAP_MARK: begin
					we = rise;
					flag = rise;
					val = {ramp_index, counter_value[CNT_W-RAMP_W-1:0]};
				end
				default: ;
			endcase
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				cmp_prev_q <= 1'b0;
				vprev_q <= 1'b0;
				fstate_q <= 1'b0;
				alt_q <= 1'b0;
				trend_q <= 1'b0;
				blk_cnt_q <= 14'h0000;
				restart_q <= 1'b0;
				flag_q <= 1'b0;
				hw_q <= 1'b0;
				sw_q <= 1'b0;
			end else begin
				cmp_prev_q <= cmp;
				vprev_q <= valid;
				fstate_q <= fstate_d;
				if (blk_go) begin
					blk_cnt_q <= blk_load;
				end else if (blk_cnt_q != 14'h0000) begin
					blk_cnt_q <= blk_cnt_q - 14'h0001;
				end
				if (cycle_end) begin
					alt_q <= fst[1-n];
				end
				// trend remembers the direction of the step at the last fault rise, captured or not
				if (rise) begin
					trend_q <= up;
				end
				restart_q <= fstate_q && !fstate_d && fc.restart;
				flag_q <= flag;
				hw_q <= fstate_d && fc.halt == pfd_pkg::HALT_HW;
				sw_q <= fstate_d && fc.halt == pfd_pkg::HALT_SW;
			end
		end

		assign nr_req[n] = fstate_q && fc.halt == pfd_pkg::HALT_NR;
		assign fst[n] = fstate_q;
		assign cap_we[n] = we;
		assign cap_val[n] = val;
		assign fault_state[n] = fstate_q;
		assign fault_restart[n] = restart_q;
		assign fault_event_flag[n] = flag_q;
		assign fault_halt_hw[n] = hw_q;
		assign fault_halt_sw[n] = sw_q;
	end

	// non-recoverable state: a new fault beats a software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nrf_q <= 1'b0;
		end else if (evt_f[2] || evt_f[3] || |nr_req) begin
			nrf_q <= 1'b1;
		end else if (wr_go && awaddr_q == pfd_pkg::STATUS_OFF && wstrb_q[0]
				&& wdata_q[pfd_pkg::NRF_BIT]) begin
			nrf_q <= 1'b0;
		end
	end

	assign nonrecov_fault = nrf_q;

	// ------------------------------------------------------------
	// output matrix and dead time
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			case (wex_q.output_routing_sel)
				2'h0: mtx[i] = compare_output_state[i % 4];
				2'h1: mtx[i] = compare_output_state[i % 2];
				2'h2: mtx[i] = compare_output_state[0];
				default: mtx[i] = (i == 0) ? compare_output_state[0] : compare_output_state[1];
			endcase
		end
	end

	for (genvar x = 0; x < 4; x++) begin : g_dt
		logic prev_q, en;
		logic [7:0] cnt_q, cnt_d;

		assign en = wex_q.deadtime_gen_enable[x];

		// a source edge restarts the count even if the last one is unfinished
		always_comb begin
			if (mtx[x] != prev_q) begin
				cnt_d = mtx[x] ? wex_q.deadtime_low_cycles
					: wex_q.deadtime_high_cycles;
			end else if (cnt_q != 8'h00) begin
				cnt_d = cnt_q - 8'h01;
			end else begin
				cnt_d = 8'h00;
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				prev_q <= 1'b0;
				cnt_q <= 8'h00;
			end else begin
				prev_q <= mtx[x];
				cnt_q <= cnt_d;
			end
		end

		assign wv[x] = en ? (mtx[x] && cnt_d == 8'h00) : mtx[x];
		assign wv[x+4] = en ? (!mtx[x] && cnt_d == 8'h00) : mtx[x+4];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wo_q <= 8'h00;
			oe_q <= 8'h00;
		end else if (nrf_q) begin
			wo_q <= drv_q.nonrecov_override_level;
			oe_q <= drv_q.nonrecov_override_en;
		end else begin
			wo_q <= wv ^ drv_q.output_invert;
			oe_q <= 8'hff;
		end
	end

	assign wo_out = wo_q;
	assign wo_oe = oe_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	blank_window_a: assert property ($rose(g_rf[0].fstate_q) |->
		$past(g_rf[0].blk_cnt_q) == 14'h0000)
		else $error("fault accepted inside blanking window");
	blank_presc_a: assert property (g_rf[0].blk_go && fc_q[0].blank_prescale_sel
		|=> g_rf[0].blk_cnt_q == {$past(fc_q[0].blank_duration), 6'h00})
		else $error("prescaled blanking count wrong");
	plain_plain_fault_capture_a: assert property (g_rf[0].rise && fc_q[0].plain_fault_capture == pfd_pkg::CAP_PLAIN
		|=> fault_event_flag[0] && cc_q[$past(fc_q[0].fault_capture_channel)]
		== $past(counter_value))
		else $error("plain capture missed");
	lower_plain_fault_capture_a: assert property (g_rf[0].rise && fc_q[0].plain_fault_capture == pfd_pkg::CAP_LOWER
		&& counter_value >= g_rf[0].last |=> !fault_event_flag[0])
		else $error("capture flagged without a new minimum");
	keep_hold_a: assert property (fault_state[0] && !g_rf[0].valid && fc_q[0].keep
		&& !cycle_end |=> fault_state[0])
		else $error("kept fault released before cycle end");
	alt_latch_a: assert property (cycle_end |=> g_rf[0].alt_q == $past(fst[1]))
		else $error("alternate fault state not latched");
	nr_override_a: assert property (nrf_q |=> wo_oe == $past(drv_q.nonrecov_override_en)
		&& wo_out == $past(drv_q.nonrecov_override_level))
		else $error("non-recoverable override wrong");
	invert_out_a: assert property (!nrf_q |=> wo_out == $past(wv ^ drv_q.output_invert))
		else $error("output inversion wrong");
	dead_pair_a: assert property (g_dt[0].en && g_dt[0].cnt_d != 8'h00
		|=> wo_out[0] == $past(drv_q.output_invert[0]) || $past(nrf_q))
		else $error("low side active during dead time");

endmodule
`default_nettype wire

// *** bench/pfd_far_end.sv ***
// pfd_far_end: counter core and event system as seen from the fault block.
// assumes bench requests change right after rising edges of aclk.
`timescale 1ns/1ps
`default_nettype none
module pfd_far_end (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bench requests
	input wire logic [1:0] ev_req,
	input wire logic nr_req,
	input wire logic [23:0] cnt_set,
	input wire logic [3:0] cmp_set,
	// toward the block
	output logic [1:0] match_capture_event_in,
	output logic timer_event_in_0,
	output logic timer_event_in_1,
	output logic [23:0] counter_value,
	output logic [3:0] compare_output_state,
	output logic period_start,
	output logic cycle_end
);
	logic [3:0] tick_q;
	// levels pass straight through: an asynchronous route, no pulse shaping
	assign match_capture_event_in = ev_req;
	assign timer_event_in_0 = nr_req;
	assign timer_event_in_1 = 1'b0;
	assign counter_value = cnt_set;
	assign compare_output_state = cmp_set;
	assign period_start = (tick_q == 4'h0);
	assign cycle_end = (tick_q == 4'hf);
	always_ff @(posedge aclk) begin
		if (!aresetn) tick_q <= 4'h0;
		else tick_q <= tick_q + 4'h1;
	end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// testbench: register bus, dead time, capture, halt, inversion and override checks.
// assumes pfd_fault_ctrl with default widths and pfd_far_end beside it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, nonrecov_fault, nr_req;
	logic [7:0] awaddr, araddr, wo_out, wo_oe;
	logic [31:0] wdata, rdata, rd_q;
	logic [3:0] wstrb, cmp_set;
	logic [1:0] bresp, rresp, fault_state, fault_halt_hw, fault_halt_sw, ev_req;
	logic [1:0] fault_restart, fault_event_flag, mce, rsp_q;
	logic [23:0] cnt_set, cnt;
	logic [3:0] cmp;
	logic tev0, tev1, pst, cend;
	int mismatches = 0;
	int num_checks = 0;
	int flag_cnt = 0;
	int rst_cnt = 0;
	// one-cycle pulses are counted here so a task cannot miss them
	always @(posedge aclk) begin
		if (fault_event_flag[0] === 1'b1) flag_cnt <= flag_cnt + 1;
		if (fault_restart[0] === 1'b1) rst_cnt <= rst_cnt + 1;
	end
	pfd_far_end far (.aclk(aclk), .aresetn(aresetn), .ev_req(ev_req), .nr_req(nr_req),
		.cnt_set(cnt_set), .cmp_set(cmp_set), .match_capture_event_in(mce),
		.timer_event_in_0(tev0), .timer_event_in_1(tev1), .counter_value(cnt),
		.compare_output_state(cmp), .period_start(pst), .cycle_end(cend));
	pfd_fault_ctrl dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .match_capture_event_in(mce),
		.timer_event_in_0(tev0), .timer_event_in_1(tev1), .counter_value(cnt),
		.ramp_index(2'h0), .period_start(pst), .cycle_end(cend),
		.compare_output_state(cmp), .fault_state(fault_state),
		.fault_halt_hw(fault_halt_hw), .fault_halt_sw(fault_halt_sw),
		.fault_restart(fault_restart), .fault_event_flag(fault_event_flag),
		.nonrecov_fault(nonrecov_fault), .wo_out(wo_out), .wo_oe(wo_oe));
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// waits are ended only by the watchdog: the slave sets the pace
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rsp_q = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd_q = rdata;
		rsp_q = rresp;
		rready <= 1'b0;
	endtask
	// bounded wait on a fault output reaching a level; running out is a mismatch
	task automatic till(input logic nr, input logic v);
		int n;
		for (n = 0; n < 30 && (nr ? nonrecov_fault : fault_state[0]) !== v; n++) @(posedge aclk);
		if (n == 30) mismatches++;
		@(posedge aclk);
	endtask
	task automatic t_regs;
		rd(pfd_pkg::WEX_OFF);
		chk(rd_q, 32'h0000_0000);
		rd(8'h40);
		chk(rd_q, 32'h0000_0000);
		chk(rsp_q, pfd_pkg::RESP_SLVERR);
		wr(8'h40, 32'hffff_ffff);
		chk(rsp_q, pfd_pkg::RESP_SLVERR);
		wr(pfd_pkg::WEX_OFF, 32'hffff_ffff);
		chk(rsp_q, pfd_pkg::RESP_OKAY);
		rd(pfd_pkg::WEX_OFF);
		chk(rd_q, 32'hffff_0f03);
		wr(pfd_pkg::WEX_OFF, 32'h0);
		$display("test regs done");
	endtask
	// pair 0: low side on output 0, high side on output 4
	task automatic t_deadtime;
		wr(pfd_pkg::WEX_OFF, 32'h0302_0100);
		cmp_set <= 4'he;
		repeat (3) @(posedge aclk);
		chk({wo_out[4], wo_out[0]}, 2'h0);
		repeat (3) @(posedge aclk);
		chk({wo_out[4], wo_out[0]}, 2'h2);
		cmp_set <= 4'hf;
		repeat (2) @(posedge aclk);
		chk({wo_out[4], wo_out[0]}, 2'h0);
		repeat (3) @(posedge aclk);
		chk({wo_out[4], wo_out[0]}, 2'h1);
		wr(pfd_pkg::WEX_OFF, 32'h0);
		$display("test deadtime done");
	endtask
	task automatic t_invert;
		wr(pfd_pkg::DRV_OFF, 32'h00ff_0000);
		repeat (3) @(posedge aclk);
		chk({wo_oe, wo_out}, 16'hffff);
		cmp_set <= 4'hf;
		repeat (3) @(posedge aclk);
		chk(wo_out, 8'h00);
		wr(pfd_pkg::DRV_OFF, 32'h0);
		$display("test invert done");
	endtask
	// filter 4, plain capture to channel 2, hardware halt, restart on
	task automatic t_capture;
		cnt_set <= 24'h000123;
		wr(pfd_pkg::FLT0_OFF, 32'h0400_1981);
		ev_req <= 2'h1;
		repeat (5) @(posedge aclk);
		chk(fault_state[0], 1'b0);
		till(1'b0, 1'b1);
		chk({fault_halt_sw, fault_halt_hw}, 4'h1);
		chk(flag_cnt, 1);
		rd(8'h28);
		chk(rd_q, 32'h0000_0123);
		ev_req <= 2'h0;
		till(1'b0, 1'b0);
		chk(fault_state, 2'h0);
		chk(rst_cnt, 1);
		$display("test capture done");
	endtask
	task automatic t_nonrecov;
		wr(pfd_pkg::DRV_OFF, 32'h0000_050f);
		nr_req <= 1'b1;
		till(1'b1, 1'b1);
		chk({wo_oe, 4'h0, wo_out[3:0]}, 16'h0f05);
		rd(pfd_pkg::STATUS_OFF);
		chk(rd_q[4], 1'b1);
		// a clear while the input still stands must lose
		wr(pfd_pkg::STATUS_OFF, 32'h0000_0010);
		rd(pfd_pkg::STATUS_OFF);
		chk(rd_q[4], 1'b1);
		nr_req <= 1'b0;
		repeat (6) @(posedge aclk);
		wr(pfd_pkg::STATUS_OFF, 32'h0000_0010);
		rd(pfd_pkg::STATUS_OFF);
		chk(rd_q[4], 1'b0);
		chk(wo_oe, 8'hff);
		$display("test nonrecov done");
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		mismatches++;
		finish_test();
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, nr_req} = 7'h0;
		{awaddr, araddr, wdata, ev_req, cnt_set, cmp_set} = 78'h0;
		wstrb = 4'hf;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_invert();
		t_deadtime();
		t_capture();
		t_nonrecov();
		finish_test();
	end
endmodule
`default_nettype wire
